// File: hw/aprc_consts.svh
// Constants for the converter phase, ready and calibration block.
// Assumes the clock is the modulator clock and one count is one period.
`ifndef APRC_CONSTS_SVH
`define APRC_CONSTS_SVH

// ============================================================
// Widths
`define APRC_DATA_W        24
`define APRC_PHASE_W       12
`define APRC_CNT_W         13
`define APRC_OSR_SEL_W     3

// ============================================================
// Oversampling ratio
// Ratio is 32 shifted left by the selector; selector 7 is 4096
`define APRC_OSR_MIN       13'h0020
`define APRC_OSR_SEL_MAX   3'h7
// Effective offset resolution at ratio 32, in bits
`define APRC_RES_MIN       5'h11

// ============================================================
// Timing, in modulator clock periods
`define APRC_GAIN_LAT_CLK  24

// ============================================================
// Codes and reset values
`define APRC_CODE_MAX      24'h7fffff
`define APRC_CODE_MIN      24'h800000
`define APRC_GAIN_ONE      26'h0800000
`define APRC_GAIN_SHIFT    23
`define APRC_FLAGS_RST     2'h3
`define APRC_MERGE_RST     1'h1

`endif

// File: hw/aprc_pkg.sv
// Types for the converter phase, ready and calibration block.
// Assumes aprc_consts.svh is on the include path.
`include "aprc_consts.svh"

package aprc_pkg;

  // ============================================================
  // Per-channel calibration trims
  typedef struct packed {
    logic [`APRC_DATA_W-1:0] offset;
    logic [`APRC_DATA_W-1:0] gain;
  } aprc_trim_t;

  // ============================================================
  // Global conversion settings
  typedef struct packed {
    logic [`APRC_OSR_SEL_W-1:0] osr_sel;
    logic                       ready_pulse_merge;
    logic                       offset_correction_enable;
    logic                       gain_correction_enable;
  } aprc_cfg_t;

endpackage

// File: hw/aprc_core.sv
// Ready timing, skew, status flags and offset/gain correction for a
// two-channel delta-sigma converter.
// Assumes clk is the modulator clock and raw_sample holds each
// channel's newest filter output whenever that channel's word is due.
//
// Overview of operation
// RL1 - Every skew write, same value or not, restarts both channels.
// RL2 - Skew code sign bit moves from bit 11 at 4096 to bit 4 at 32.
// RL3 - Skew spans minus half ratio to half ratio minus one periods.
// RL4 - Skew is two's complement, one modulator period per count.
// RL5 - Oscillator runs only with external clock off, never in two-wire mode.
// RL6 - External clock on: second oscillator pin high selects two-wire mode.
// RL7 - Pending flags are read-only and reset to one.
// RL8 - A channel's pending flag clears when its output word updates.
// RL9 - Reading the status register sets all pending flags back to one; a flag updated in the same cycle clears instead.
// RL10 - Merged mode updates both flags with lagging channel; else each alone. A held channel's flag is left as it is.
// RL11 - Unmerged mode sends both channels' ready pulses to the ready pin.
// RL12 - Merged mode, the default, sends only the lagging channel's pulse.
// RL13 - Merged mode latches all active channels together at lagging ready.
// RL14 - Global enables; output is (raw plus offset) times (one plus gain).
// RL15 - Two-wire mode disables offset and gain correction.
// RL16 - Offset trim is added with data weight and no extra latency.
// RL17 - Only offset bits within effective resolution are added; 17 at 32.
// RL18 - No correction is applied to a channel held in reset or shutdown.
// RL19 - Disabling offset correction keeps the stored trims intact.
// RL20 - Gain trim is signed, weight two to minus 23, plus one as factor.
// RL21 - Gain enable delays all ready pulses by 24 modulator periods.
// RL22 - Gain applies from the first ready after it is enabled.
// RL23 - Positive skew makes channel 0 lag channel 1; negative makes it lead.
// RL24 - Results outside range clamp to the maximum or minimum code.
// RL25 - Product is scaled back 23 bits before clamping.
`timescale 1ns/1ps
`include "aprc_consts.svh"

module aprc_core #(
  parameter int GAIN_LAT = `APRC_GAIN_LAT_CLK
) (
  input  wire  logic                                   clk,
  input  wire  logic                                   reset,
  input  wire  aprc_pkg::aprc_cfg_t                    cfg,
  input  wire  logic [`APRC_PHASE_W-1:0]               phase_code,
  input  wire  logic                                   phase_write,
  input  wire  aprc_pkg::aprc_trim_t [1:0]             channel_trim,
  input  wire  logic [1:0]                             channel_hold,
  input  wire  logic                                   external_clock_select,
  input  wire  logic                                   second_oscillator_pin,
  input  wire  logic                                   status_read,
  input  wire  logic [1:0][`APRC_DATA_W-1:0]           raw_sample,
  output logic                                         oscillator_enable,
  output logic                                         two_wire_mode,
  output logic                                         channel_restart,
  output logic [1:0]                                   pending_sample_flags,
  output logic                                         ready_output_pin_n,
  output logic [1:0][`APRC_DATA_W-1:0]                 channel_out
);

  // ============================================================
  // Interface mode and oscillator
  logic second_oscillator_pin_meta_q;
  logic second_oscillator_pin_sync_q;
  logic osc_en_q;
  logic two_wire_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      second_oscillator_pin_meta_q <= 1'b0;
      second_oscillator_pin_sync_q <= 1'b0;
    end else begin
      second_oscillator_pin_meta_q <= second_oscillator_pin;
      second_oscillator_pin_sync_q <= second_oscillator_pin_meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      two_wire_q <= 1'b0;
      osc_en_q   <= 1'b1;
    end else begin
      // Pin doubles as mode select only with the external clock
      two_wire_q <= external_clock_select & second_oscillator_pin_sync_q;   // [RL6]
      osc_en_q   <= ~external_clock_select;                // [RL5]
    end
  end

  assign oscillator_enable = osc_en_q;
  assign two_wire_mode     = two_wire_q;

  // ============================================================
  // Word period counter and skew
  logic [`APRC_CNT_W-1:0]   oversampling_ratio;
  logic [`APRC_CNT_W-1:0]   half;
  logic [`APRC_CNT_W-1:0]   cnt_q;
  logic [`APRC_PHASE_W-1:0] phase_shl;
  logic [`APRC_PHASE_W-1:0] skew;
  logic [`APRC_CNT_W-1:0]   pos0;
  logic [2:0]               drop;
  logic                     restart_q;
  logic [1:0]               active;

  assign oversampling_ratio    = `APRC_OSR_MIN << cfg.osr_sel;
  assign half   = oversampling_ratio >> 1;
  assign drop   = `APRC_OSR_SEL_MAX - cfg.osr_sel;
  assign active = ~channel_hold;

  // Sign bit sits at bit 4 plus the ratio selector, so the code is
  // pushed up to bit 11 and brought back with sign extension
  assign phase_shl = phase_code << drop;                              // [RL2]
  assign skew = `APRC_PHASE_W'($signed(phase_shl) >>> drop);          // [RL4]
  // Channel 1 is the reference at half a word; channel 0 sits skew
  // periods later, wrapped into one word period
  assign pos0 = (half + {skew[`APRC_PHASE_W-1], skew})
                & (oversampling_ratio - 1'b1);                        // [RL3] [RL23]

  always_ff @(posedge clk) begin
    if (reset || phase_write) begin
      cnt_q <= '0;                                       // [RL1]
    end else if (cnt_q >= oversampling_ratio - 1'b1) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= phase_write;                          // [RL1]
    end
  end

  assign channel_restart = restart_q;

  // ============================================================
  // Raw word events and sample capture
  logic [1:0]                   ev_raw;
  logic [1:0][`APRC_DATA_W-1:0] hold_q;

  assign ev_raw[1] = (cnt_q == half) & active[1] & ~phase_write;
  assign ev_raw[0] = (cnt_q == pos0) & active[0] & ~phase_write; // [RL23]

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ev_raw[c]) begin
          hold_q[c] <= raw_sample[c];
        end
      end
    end
  end

  // ============================================================
  // Gain pipeline latency
  // GAIN_LAT must stay below the ratio, or a delayed word would
  // meet the next raw word of the same channel
  logic [1:0] dly_q [GAIN_LAT];
  logic [1:0] gain_q;
  logic       gain_go;
  logic [1:0] ev;

  assign gain_go = cfg.gain_correction_enable & ~two_wire_q;    // [RL15]

  always_ff @(posedge clk) begin
    if (reset || phase_write) begin
      for (int i = 0; i < GAIN_LAT; i++) begin
        dly_q[i] <= 2'h0;
      end
    end else begin
      dly_q[0] <= ev_raw & {2{gain_go}};
      for (int i = 1; i < GAIN_LAT; i++) begin
        dly_q[i] <= dly_q[i-1];
      end
    end
  end

  // Each word keeps the gain setting it was taken with, so turning
  // gain on or off neither drops nor repeats a ready pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      gain_q <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ev_raw[c]) begin
          gain_q[c] <= gain_go;                                 // [RL22]
        end
      end
    end
  end

  // Words taken with gain on leave through the delay line
  assign ev = (ev_raw & ~{2{gain_go}}) | dly_q[GAIN_LAT-1];     // [RL21]

  // ============================================================
  // Ready merging
  logic [1:0] seen_q;
  logic [1:0] seen_all;
  logic       fire;
  logic [1:0] upd;
  logic       pulse;

  assign seen_all = seen_q | ev;
  // Lagging channel is whichever active one arrives last
  assign fire = (active != 2'h0) && ((seen_all & active) == active)
                && (|ev);                                       // [RL12]

  always_ff @(posedge clk) begin
    if (reset || phase_write || fire) begin
      seen_q <= 2'h0;
    end else begin
      seen_q <= seen_all & active;
    end
  end

  always_comb begin
    if (cfg.ready_pulse_merge) begin
      upd   = {2{fire}} & active;                        // [RL13]
      pulse = fire;                                      // [RL12]
    end else begin
      upd   = ev;
      pulse = |ev;                                       // [RL11]
    end
  end

  // ============================================================
  // Offset and gain correction
  function automatic logic [`APRC_DATA_W-1:0] correct(
    input logic [`APRC_DATA_W-1:0] s,
    input aprc_pkg::aprc_trim_t    t,
    input logic                    off_en,
    input logic                    gain_en,
    input logic [2:0]              dbits
  );
    logic [`APRC_DATA_W-1:0] off;
    logic [24:0]             sum;
    logic [25:0]             fac;
    logic [50:0]             prod;
    logic [27:0]             scaled;
    logic [`APRC_DATA_W-1:0] res;
    // Bits below the effective resolution are dropped
    off = (t.offset >> dbits) << dbits;                         // [RL17]
    if (!off_en) begin
      off = '0;                                                 // [RL19]
    end
    sum  = {s[23], s} + {off[23], off};                         // [RL16]
    fac  = `APRC_GAIN_ONE + {{2{t.gain[23]}}, t.gain};          // [RL20]
    prod = 51'($signed(sum) * $signed(fac));                    // [RL14]
    if (gain_en) begin
      scaled = prod[`APRC_GAIN_SHIFT +: 28];                    // [RL25]
    end else begin
      scaled = {{3{sum[24]}}, sum};
    end
    if (!scaled[27] && (scaled[26:23] != 4'h0)) begin
      res = `APRC_CODE_MAX;                                     // [RL24]
    end else if (scaled[27] && (scaled[26:23] != 4'hf)) begin
      res = `APRC_CODE_MIN;                                     // [RL24]
    end else begin
      res = scaled[23:0];
    end
    return res;
  endfunction

  logic                          cal_ok;
  logic [1:0][`APRC_DATA_W-1:0] src;
  logic [1:0]                   gen;
  logic [1:0][`APRC_DATA_W-1:0] corr;

  // Correction is bypassed in two-wire mode
  assign cal_ok = ~two_wire_q;                                  // [RL15]

  // A word that updates in its own event cycle is taken straight
  // from the filter, as the holding register loads only at that edge
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (ev_raw[c]) begin
        src[c] = raw_sample[c];                                 // [RL16]
        gen[c] = gain_go;
      end else begin
        src[c] = hold_q[c];
        gen[c] = gain_q[c];                                     // [RL22]
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      corr[c] = correct(src[c], channel_trim[c],
                        cfg.offset_correction_enable & cal_ok,
                        gen[c] & cal_ok, drop);
    end
  end

  // ============================================================
  // Output words
  logic [1:0][`APRC_DATA_W-1:0] out_q;

  always_ff @(posedge clk) begin
    if (reset || phase_write) begin
      out_q <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (channel_hold[c]) begin
          out_q[c] <= '0;                                       // [RL18]
        end else if (upd[c]) begin
          out_q[c] <= corr[c];                                  // [RL14]
        end
      end
    end
  end

  assign channel_out = out_q;

  // ============================================================
  // Pending-sample flags and ready pin
  logic [1:0] flags_q;
  logic       ready_n_q;

  // An update in the same cycle as a status read wins over the read
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= `APRC_FLAGS_RST;                               // [RL7]
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (upd[c]) begin
          flags_q[c] <= 1'b0;                                   // [RL8] [RL10]
        end else if (status_read) begin
          flags_q[c] <= 1'b1;                                   // [RL9]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ready_n_q <= 1'b1;
    end else begin
      ready_n_q <= ~pulse;                                      // [RL11]
    end
  end

  assign pending_sample_flags = flags_q;
  assign ready_output_pin_n   = ready_n_q;

endmodule

// File: tb/aprc_host.sv
// Host model: reads the status register after every ready pulse while read_enable is high.
// Assumes ready is an active-low one-cycle pulse.
`timescale 1ns/1ps
module aprc_host (
  input  wire logic             clk,
  input  wire logic             read_enable,
  input  wire logic             ready_output_pin_n,
  input  wire logic [1:0][23:0] channel_out,
  output logic                  status_read,
  output logic [1:0][23:0]      word_seen
);
  // ====
  // Read
  initial status_read = 1'b0;
  // Sampling on the falling edge keeps the read one cycle long
  always @(negedge clk) begin
    status_read <= read_enable && !ready_output_pin_n;
    if (!ready_output_pin_n) begin
      word_seen <= channel_out;
    end
  end
endmodule

// File: tb/aprc_core_props.sv
// Port assertions for the phase, ready and calibration core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module aprc_core_props (
  input wire logic                clk,
  input wire logic                reset,
  input wire aprc_pkg::aprc_cfg_t cfg,
  input wire logic                phase_write,
  input wire logic [1:0]          channel_hold,
  input wire logic                external_clock_select,
  input wire logic                status_read,
  input wire logic                oscillator_enable,
  input wire logic                two_wire_mode,
  input wire logic                channel_restart,
  input wire logic [1:0]          pending_sample_flags,
  input wire logic                ready_output_pin_n,
  input wire logic [1:0][23:0]    channel_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // Properties
  AST_RESTART: assert property (phase_write |=> channel_restart)
    else $error("no restart after skew write");
  AST_RESTART_CAUSE: assert property (
    channel_restart |-> $past(phase_write))
    else $error("restart without skew write");
  AST_OSC: assert property (!$past(reset) |->
    oscillator_enable == !$past(external_clock_select))
    else $error("oscillator enable wrong");
  AST_TWO_WIRE: assert property (two_wire_mode |-> !oscillator_enable)
    else $error("oscillator on in two-wire mode");
  AST_READY_ONE: assert property (
    !ready_output_pin_n |=> ready_output_pin_n)
    else $error("ready pulse longer than one cycle");
  AST_READ_SETS: assert property (status_read |=>
    pending_sample_flags == 2'h3 || !ready_output_pin_n)
    else $error("status read left flags clear");
  // Mode switches may leave one odd pulse, so only a clean run is judged
  AST_MERGE_FLAGS: assert property (cfg.ready_pulse_merge &&
    channel_hold == 2'h0 && $fell(ready_output_pin_n)
    |-> pending_sample_flags == 2'h0)
    else $error("merged pulse left a flag set");
  AST_HELD_ZERO: assert property (
    channel_hold[0] && $past(channel_hold[0]) |-> channel_out[0] == 24'h0)
    else $error("held channel output not zero");
  AST_FLAG_RISE: assert property (
    !$past(reset) && $rose(pending_sample_flags[0])
    |-> $past(status_read) || $past(phase_write))
    else $error("flag set without a read");
endmodule

bind aprc_core aprc_core_props u_props (
  .clk(clk), .reset(reset), .cfg(cfg), .phase_write(phase_write),
  .channel_hold(channel_hold), .status_read(status_read),
  .external_clock_select(external_clock_select),
  .oscillator_enable(oscillator_enable), .two_wire_mode(two_wire_mode),
  .channel_restart(channel_restart), .channel_out(channel_out),
  .pending_sample_flags(pending_sample_flags),
  .ready_output_pin_n(ready_output_pin_n));

// File: tb/aprc_core_tb.sv
// Testbench for the phase, ready and calibration core.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module aprc_core_tb;
  localparam int GL = 4;
  logic                       clk, reset, phase_write, ecs, pin;
  logic                       status_read, rd_en, osc_en, two_wire;
  logic                       restart, ready_n;
  logic [11:0]                phase_code;
  logic [1:0]                 hold, flags;
  logic [1:0][23:0]           raw, outw, seen;
  aprc_pkg::aprc_cfg_t        cfg;
  aprc_pkg::aprc_trim_t [1:0] trim;
  int                         miscompares, checked;

  aprc_core #(.GAIN_LAT(GL)) dut (
    .clk(clk), .reset(reset), .cfg(cfg), .phase_code(phase_code),
    .phase_write(phase_write), .channel_trim(trim), .channel_hold(hold),
    .external_clock_select(ecs), .second_oscillator_pin(pin),
    .status_read(status_read), .raw_sample(raw),
    .oscillator_enable(osc_en), .two_wire_mode(two_wire),
    .channel_restart(restart), .pending_sample_flags(flags),
    .ready_output_pin_n(ready_n), .channel_out(outw));
  aprc_host host (.clk(clk), .read_enable(rd_en), .ready_output_pin_n(ready_n),
    .channel_out(outw), .status_read(status_read), .word_seen(seen));

  // =====
  // Tasks
  task automatic chk_v(input string what, input logic [47:0] exp, got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_t(input string what, input int exp, got);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write the skew, time the first two ready pulses from the write edge
  task automatic run(input logic [11:0] code, input int e0, e1,
                     input logic [1:0] f0, input logic [47:0] o);
    int t[2] = '{-1, -1};
    int k = 0;
    phase_code = code;
    phase_write = 1'b1;
    @(negedge clk);
    phase_write = 1'b0;
    chk_v("restart", 48'h1, {47'h0, restart});
    for (int n = 1; n < 9000 && k < 2; n++) begin
      @(negedge clk);
      if (ready_n === 1'b0) begin
        if (k == 0)
          chk_v("flags", {46'h0, f0}, {46'h0, flags});
        t[k] = n;
        k++;
      end
    end
    @(negedge clk);
    chk_t("first ready", e0, t[0]);
    chk_t("second ready", e1, t[1]);
    chk_v("words", o, seen);
  endtask

  // =====
  // Tests
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
  initial begin
    {reset, hold, ecs, pin, rd_en, phase_write} = {1'b1, 6'h0};
    {cfg, phase_code, trim} = '0;
    raw = {24'hffff00, 24'h001000};
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk_v("flags after reset", 48'h3, {46'h0, flags});
    chk_v("oscillator", 48'h1, {47'h0, osc_en});
    rd_en = 1'b1;
    run(12'h00f, 17, 32, 2'h1, raw);
    run(12'h010, 1, 17, 2'h2, raw);
    run(12'h7fe, 15, 17, 2'h2, raw);
    cfg.osr_sel = 3'h7;
    run(12'h7ff, 2049, 4096, 2'h1, raw);
    run(12'h800, 1, 2049, 2'h2, raw);
    cfg.osr_sel = 3'h1;
    run(12'h01f, 33, 64, 2'h1, raw);
    // Merge mode is changed under reset so no stray pulse is judged
    reset = 1'b1;
    cfg = '0;
    cfg.ready_pulse_merge = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    run(12'h000, 17, 49, 2'h0, raw);
    run(12'h00f, 32, 64, 2'h0, raw);
    run(12'h7ff, 17, 49, 2'h0, raw);
    trim[0] = {24'h00017f, 24'h400000};
    trim[1].offset = 24'hffff80;
    cfg.offset_correction_enable = 1'b1;
    run(12'h000, 17, 49, 2'h0, 48'hfffe80_001100);
    cfg.gain_correction_enable = 1'b1;
    run(12'h000, 17 + GL, 49 + GL, 2'h0, 48'hfffe80_001980);
    raw[0] = 24'h7ff000;
    trim[0].offset = 24'h100000;
    run(12'h000, 21, 53, 2'h0, 48'hfffe80_7fffff);
    cfg.gain_correction_enable = 1'b0;
    {ecs, pin} = 2'h3;
    repeat (4) @(negedge clk);
    chk_v("two wire", 48'h1, {47'h0, two_wire});
    chk_v("oscillator off", 48'h0, {47'h0, osc_en});
    run(12'h000, 17, 49, 2'h0, raw);
    {ecs, pin, hold} = 4'h1;
    run(12'h00f, 17, 49, 2'h1, 48'hfffe80_000000);
    wrap_up;
  end
endmodule
